// ### hw/ddr_pkg.sv
// constants, types and register map for the ddr dual-port sample receiver
// assumes an axi4-lite master on aclk and a host driving the ddr link pins
//
// Operation
// - delay loop accepts the data clock range and derives a sampling clock
// - input samples captured on both rising and falling sampling clock edges
// - zero offset places sampling a quarter period after the data clock
// - four-bit register field offsets the sampling phase from nominal
// - each offset step moves phase one fixed increment, magnitude kept below eight
// - sampling delay adjusted automatically or by manual programming
// - outgoing data clock at incoming clock frequency and phase, gated copy of the incoming clock
// - outgoing data clock disabled after reset until software enables it
// - readable status bit set once the delay loop locks
// - captured samples cross to the internal domain through a small fifo
package ddr_pkg;

   // ==========================================================
   // sizes
   localparam int SAMPLE_W = 14;
   localparam int DEPTH    = 8;
   localparam int PTR_W    = 3;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_PHASE   = 8'h0A;
   localparam logic [7:0] IDX_APPLIED = 8'h0B;
   localparam logic [7:0] IDX_CLKOUT  = 8'h0C;
   localparam logic [7:0] IDX_STATUS  = 8'h0E;
   localparam logic [7:0] ADDR_PHASE   = {IDX_PHASE[5:0], 2'b00};
   localparam logic [7:0] ADDR_APPLIED = {IDX_APPLIED[5:0], 2'b00};
   localparam logic [7:0] ADDR_CLKOUT  = {IDX_CLKOUT[5:0], 2'b00};
   localparam logic [7:0] ADDR_STATUS  = {IDX_STATUS[5:0], 2'b00};

   // ==========================================================
   // field positions
   localparam int PH_AUTO_BIT   = 7;
   localparam int CLKOUT_EN_BIT = 6;
   localparam int ST_RUN_BIT    = 0;
   localparam int ST_OVF_BIT    = 1;
   localparam int ST_CLKOK_BIT  = 2;
   localparam int ST_END_BIT    = 4;
   localparam int ST_START_BIT  = 5;
   localparam int ST_WARN_BIT   = 6;
   localparam int ST_LOCK_BIT   = 7;

   // ==========================================================
   // reset values
   localparam logic [7:0] PHASE_RST  = 8'h00;
   localparam logic [7:0] CLKOUT_RST = 8'h00;

   // ==========================================================
   // phase steps of 11.25 degrees; 8 steps make the nominal 90 degrees
   localparam logic [4:0]        NOMINAL_STEPS = 5'h08;
   localparam logic signed [3:0] STEP_MAX      = 4'sh7;

   // ==========================================================
   // cycle counts
   localparam logic [7:0] LOCK_CYCLES = 8'h40;
   localparam logic [7:0] HB_WRAP     = 8'hFF;
   localparam logic [9:0] CLK_TIMEOUT = 10'h200;
   localparam logic [7:0] AUTO_PERIOD = 8'hFF;

   // ==========================================================
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [SAMPLE_W-1:0] port_zero_sample_pos;
      logic [SAMPLE_W-1:0] port_one_sample_pos;
   } ddr_port_pair_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] p0_rise;
      logic [SAMPLE_W-1:0] p1_rise;
      logic [SAMPLE_W-1:0] p0_fall;
      logic [SAMPLE_W-1:0] p1_fall;
   } ddr_sample_t;

endpackage

// ### hw/ddr_rx.sv
// ddr dual-port sample receiver: link capture, fifo crossing, phase control
// assumes differential receivers and the analog delay line sit outside
`timescale 1ns/1ps

module ddr_rx (
   // system
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // axi4-lite slave
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [7:0]             awaddr,
   input  wire logic                   wvalid,
   output logic                        wready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   output logic                        bvalid,
   input  wire logic                   bready,
   output logic [1:0]                  bresp,
   input  wire logic                   arvalid,
   output logic                        arready,
   input  wire logic [7:0]             araddr,
   output logic                        rvalid,
   input  wire logic                   rready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   // link
   input  wire logic                   incoming_data_clock,
   input  wire ddr_pkg::ddr_port_pair_t link_pins,
   output logic                        outgoing_data_clock,
   // delay line
   output logic [4:0]                  derived_sampling_clock_phase,
   input  wire logic                   dl_early,
   input  wire logic                   dl_late,
   // converter side
   output ddr_pkg::ddr_sample_t        sample_data,
   output logic                        sample_valid,
   input  wire logic                   sample_ready
);
   import ddr_pkg::*;

   // ==========================================================
   // declarations
   logic [4:0]     a_in;
   logic [4:0]     as1_q, as2_q, as3_q, af_q;
   logic [1:0]     l_in;
   logic [1:0]     ls1_q, ls2_q, ls3_q, lf_q;
   logic           lrst_n;
   ddr_port_pair_t rise_q, fall_q;
   logic           have_q;
   ddr_sample_t    mem_q [DEPTH];
   logic [PTR_W:0] wbin_q, wgray_q, rbin_q, rgray_q;
   logic [PTR_W:0] rg1_q, rg2_q, rg3_q, wg1_q, wg2_q, wg3_q;
   logic [PTR_W:0] wbin_d, rbin_d;
   logic           full, empty, pop;
   logic           ovf_tog_q, lock_q, hb_q, gate_q;
   logic [7:0]     lock_cnt_q, hb_cnt_q;
   logic           hb_prev_q, ovf_prev_q, ovf_q;
   logic [9:0]     wd_q;
   logic           clk_ok, locked, ovf_evt;
   logic [7:0]     phase_q, clkout_q, auto_cnt_q;
   logic signed [3:0] step_q, manual_step;
   logic           aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0]     awaddr_q;
   logic [31:0]    wdata_q, rdata_q, rd_mux;
   logic [3:0]     wstrb_q;
   logic [1:0]     bresp_q, rresp_q, rd_resp;
   logic           wr_fire, ar_fire, wr_hit;
   logic           warn, at_start, at_end;

   // ==========================================================
   // crossings: three flops, a change counts once stages two and three agree
   assign a_in = {dl_late, dl_early, ovf_tog_q, lock_q, hb_q};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         as1_q <= '0;
         as2_q <= '0;
         as3_q <= '0;
         af_q  <= '0;
      end else begin
         as1_q <= a_in;
         as2_q <= as1_q;
         as3_q <= as2_q;
         af_q  <= (af_q & (as2_q ^ as3_q)) | (as3_q & ~(as2_q ^ as3_q));
      end
   end

   // reset itself travels here, so these flops carry no reset
   assign l_in = {clkout_q[CLKOUT_EN_BIT], aresetn};
   always_ff @(posedge incoming_data_clock) begin
      ls1_q <= l_in;
      ls2_q <= ls1_q;
      ls3_q <= ls2_q;
      lf_q  <= (lf_q & (ls2_q ^ ls3_q)) | (ls3_q & ~(ls2_q ^ ls3_q));
   end
   assign lrst_n = lf_q[0];

   // ==========================================================
   // dual-edge capture on the sampling clock
   always_ff @(posedge incoming_data_clock) begin
      rise_q <= link_pins;
   end

   always_ff @(negedge incoming_data_clock) begin
      fall_q <= link_pins;
   end

   // ==========================================================
   // fifo write side, one entry of four samples per link cycle
   assign wbin_d = wbin_q + {{PTR_W{1'b0}}, 1'b1};
   assign full   = (wgray_q == {~rg3_q[PTR_W:PTR_W-1], rg3_q[PTR_W-2:0]});

   always_ff @(posedge incoming_data_clock) begin
      if (!lrst_n) begin
         have_q <= 1'b0;
      end else begin
         have_q <= 1'b1;
      end
   end

   always_ff @(posedge incoming_data_clock) begin
      if (!lrst_n) begin
         wbin_q    <= '0;
         wgray_q   <= '0;
         ovf_tog_q <= 1'b0;
      end else if (have_q && !full) begin
         mem_q[wbin_q[PTR_W-1:0]] <= '{p0_rise: rise_q.port_zero_sample_pos,
                                       p1_rise: rise_q.port_one_sample_pos,
                                       p0_fall: fall_q.port_zero_sample_pos,
                                       p1_fall: fall_q.port_one_sample_pos};
         wbin_q  <= wbin_d;
         wgray_q <= wbin_d ^ (wbin_d >> 1);
      end else if (have_q) begin
         // a full fifo drops the entry; software sees the overflow flag
         ovf_tog_q <= ~ovf_tog_q;
      end
   end

   always_ff @(posedge incoming_data_clock) begin
      if (!lrst_n) begin
         rg1_q <= '0;
         rg2_q <= '0;
         rg3_q <= '0;
      end else begin
         rg1_q <= rgray_q;
         rg2_q <= rg1_q;
         rg3_q <= rg2_q;
      end
   end

   // ==========================================================
   // lock detect and heartbeat on the link clock
   always_ff @(posedge incoming_data_clock) begin
      if (!lrst_n) begin
         lock_cnt_q <= '0;
         lock_q     <= 1'b0;
      end else if (lock_cnt_q != LOCK_CYCLES) begin
         lock_cnt_q <= lock_cnt_q + 8'h01;
      end else begin
         lock_q <= 1'b1;
      end
   end

   // slow toggle so the aclk side can see the link clock running at any rate down to half the aclk rate
   always_ff @(posedge incoming_data_clock) begin
      if (!lrst_n) begin
         hb_cnt_q <= '0;
         hb_q     <= 1'b0;
      end else begin
         hb_cnt_q <= hb_cnt_q + 8'h01;
         if (hb_cnt_q == HB_WRAP) begin
            hb_q <= ~hb_q;
         end
      end
   end

   // ==========================================================
   // outgoing clock gated by a falling-edge enable to avoid runt pulses
   always_ff @(negedge incoming_data_clock) begin
      if (!lrst_n) begin
         gate_q <= 1'b0;
      end else begin
         gate_q <= lf_q[1];
      end
   end
   assign outgoing_data_clock = incoming_data_clock & gate_q;

   // ==========================================================
   // fifo read side on aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wg1_q <= '0;
         wg2_q <= '0;
         wg3_q <= '0;
      end else begin
         wg1_q <= wgray_q;
         wg2_q <= wg1_q;
         wg3_q <= wg2_q;
      end
   end

   assign empty  = (rgray_q == wg3_q);
   assign pop    = !empty && (!sample_valid || sample_ready);
   assign rbin_d = rbin_q + {{PTR_W{1'b0}}, 1'b1};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rbin_q       <= '0;
         rgray_q      <= '0;
         sample_valid <= 1'b0;
         sample_data  <= '0;
      end else if (pop) begin
         sample_data  <= mem_q[rbin_q[PTR_W-1:0]];
         sample_valid <= 1'b1;
         rbin_q       <= rbin_d;
         rgray_q      <= rbin_d ^ (rbin_d >> 1);
      end else if (sample_ready) begin
         sample_valid <= 1'b0;
      end
   end

   // ==========================================================
   // clock presence, lock and overflow status
   assign clk_ok  = (wd_q != CLK_TIMEOUT);
   assign locked  = clk_ok && af_q[1];
   assign ovf_evt = af_q[2] ^ ovf_prev_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hb_prev_q <= 1'b0;
         wd_q      <= CLK_TIMEOUT;
      end else begin
         hb_prev_q <= af_q[0];
         if (af_q[0] != hb_prev_q) begin
            wd_q <= '0;
         end else if (wd_q != CLK_TIMEOUT) begin
            wd_q <= wd_q + 10'h001;
         end
      end
   end

   // a new overflow in the clearing cycle keeps the flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_prev_q <= 1'b0;
         ovf_q      <= 1'b0;
      end else begin
         ovf_prev_q <= af_q[2];
         ovf_q      <= ovf_evt | (ovf_q & ~(wr_hit && awaddr_q == ADDR_STATUS
                                             && wdata_q[ST_OVF_BIT]));
      end
   end

   // ==========================================================
   // sampling phase: signed step, clamped to plus or minus seven
   assign manual_step = (phase_q[3:0] == 4'h8) ? -STEP_MAX
                                               : $signed(phase_q[3:0]);
   assign at_start = (step_q == -STEP_MAX);
   assign at_end   = (step_q == STEP_MAX);
   assign warn     = at_start || at_end;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_q     <= '0;
         auto_cnt_q <= '0;
      end else if (!phase_q[PH_AUTO_BIT]) begin
         step_q     <= manual_step;
         auto_cnt_q <= '0;
      end else begin
         auto_cnt_q <= auto_cnt_q + 8'h01;
         if (auto_cnt_q == AUTO_PERIOD) begin
            // delay line reports the edge early or late; step toward the eye centre
            if (af_q[3] && !af_q[4] && !at_end) begin
               step_q <= step_q + 4'sh1;
            end else if (af_q[4] && !af_q[3] && !at_start) begin
               step_q <= step_q - 4'sh1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         derived_sampling_clock_phase <= NOMINAL_STEPS;
      end else begin
         derived_sampling_clock_phase <= NOMINAL_STEPS + {step_q[3], step_q};
      end
   end

   // ==========================================================
   // axi4-lite write channel, address and data taken in either order
   assign awready = !aw_have_q;
   assign wready  = !w_have_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_hit  = wr_fire && wstrb_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            if (awaddr_q == ADDR_PHASE || awaddr_q == ADDR_CLKOUT
                || awaddr_q == ADDR_STATUS || awaddr_q == ADDR_APPLIED) begin
               bresp_q <= RESP_OKAY;
            end else begin
               bresp_q <= RESP_SLVERR;
            end
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q  <= PHASE_RST;
         clkout_q <= CLKOUT_RST;
      end else if (wr_hit) begin
         if (awaddr_q == ADDR_PHASE) begin
            phase_q <= {wdata_q[PH_AUTO_BIT], 3'h0, wdata_q[3:0]};
         end else if (awaddr_q == ADDR_CLKOUT) begin
            clkout_q <= {1'b0, wdata_q[CLKOUT_EN_BIT], 6'h00};
         end
      end
   end

   // ==========================================================
   // axi4-lite read channel
   assign arready = !rvalid_q;
   assign ar_fire = arvalid && arready;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   always_comb begin
      rd_mux  = '0;
      rd_resp = RESP_OKAY;
      if (araddr == ADDR_PHASE) begin
         rd_mux[7:0] = phase_q;
      end else if (araddr == ADDR_APPLIED) begin
         rd_mux[3:0] = step_q;
      end else if (araddr == ADDR_CLKOUT) begin
         rd_mux[7:0] = clkout_q;
      end else if (araddr == ADDR_STATUS) begin
         rd_mux[ST_LOCK_BIT]  = locked;
         rd_mux[ST_WARN_BIT]  = locked && warn;
         rd_mux[ST_START_BIT] = locked && at_start;
         rd_mux[ST_END_BIT]   = locked && at_end;
         rd_mux[ST_CLKOK_BIT] = clk_ok;
         rd_mux[ST_OVF_BIT]   = ovf_q;
         rd_mux[ST_RUN_BIT]   = clk_ok && !locked;
      end else begin
         rd_resp = RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_resp;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule // ddr_rx

// ### tb/ddr_host_model.sv
// host model: ddr data clock and two sample ports, clock still outside frames
// assumes the delay line sits outside, so samples arrive centred on the edges
`timescale 1ns/1ps
module ddr_host_model (
   // control
   input  wire logic               run,
   // link
   output logic                    incoming_data_clock,
   output ddr_pkg::ddr_port_pair_t link_pins
);
   import ddr_pkg::*;
   logic [SAMPLE_W-1:0] v;
   initial begin
      incoming_data_clock = 1'b0;
      link_pins = '0;
      v = '0;
      #7;
      forever begin
         if (run) begin
            link_pins = {v, v + 14'h0001};
            #8 incoming_data_clock = 1'b1;
            #8 v = v + 14'h0002;
            link_pins = {v, v + 14'h0001};
            #8 incoming_data_clock = 1'b0;
            #8 v = v + 14'h0002;
         end else begin
            // idle: clock still, pins keep moving so nothing stale looks valid
            link_pins = ~link_pins;
            #16;
         end
      end
   end
endmodule // ddr_host_model

// ### tb/ddr_rx_checker.sv
// checker for ddr_rx: bus handshakes, sampling phase output, link-side outputs
// assumes it is bound into ddr_rx and sees only its ports, one aclk domain
`timescale 1ns/1ps
module ddr_rx_checker (
   // system
   input wire logic                 aclk,
   input wire logic                 aresetn,
   // register bus
   input wire logic                 awvalid,
   input wire logic                 awready,
   input wire logic [7:0]           awaddr,
   input wire logic                 wvalid,
   input wire logic                 wready,
   input wire logic [31:0]          wdata,
   input wire logic [3:0]           wstrb,
   input wire logic                 bvalid,
   input wire logic                 bready,
   input wire logic [1:0]           bresp,
   input wire logic                 arvalid,
   input wire logic                 arready,
   input wire logic                 rvalid,
   input wire logic                 rready,
   input wire logic [31:0]          rdata,
   input wire logic [1:0]           rresp,
   // link and converter side
   input wire logic                 outgoing_data_clock,
   input wire logic [4:0]           derived_sampling_clock_phase,
   input wire ddr_pkg::ddr_sample_t sample_data,
   input wire logic                 sample_valid,
   input wire logic                 sample_ready
);
   import ddr_pkg::*;
   logic [7:0] aw_q;
   logic [5:0] w_q;
   logic [3:0] st;
   logic [4:0] ph_exp;
   always_ff @(posedge aclk) begin
      if (awvalid && awready) begin
         aw_q <= awaddr;
      end
   end
   always_ff @(posedge aclk) begin
      if (wvalid && wready) begin
         w_q <= {wstrb[0], wdata[7], wdata[3:0]};
      end
   end
   // -8 lies outside the legal range and acts as -7
   assign st     = (w_q[3:0] == 4'h8) ? 4'h9 : w_q[3:0];
   assign ph_exp = {st[3], st} + NOMINAL_STEPS;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // properties
   property p_ph_set;
      $rose(bvalid) && aw_q == ADDR_PHASE && w_q[5] && !w_q[4]
         |-> ##[0:3] derived_sampling_clock_phase == ph_exp;
   endproperty
   a_ph_set: assert property (p_ph_set) else $error("phase output wrong after write");
   property p_ph_range;
      derived_sampling_clock_phase >= 5'h01 && derived_sampling_clock_phase <= 5'h0F;
   endproperty
   a_ph_range: assert property (p_ph_range) else $error("phase step out of range");
   property p_clk_off;
      $rose(aresetn) |-> !outgoing_data_clock [*8];
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("output clock on after reset");
   property p_wr_resp;
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_one;
      arvalid && arready |=> rvalid;
   endproperty
   a_r_one: assert property (p_r_one) else $error("read data not one cycle after");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_err_zero;
      rvalid && rresp == RESP_SLVERR |-> rdata == 32'h00000000;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   property p_smp_hold;
      sample_valid && !sample_ready |=> sample_valid && $stable(sample_data);
   endproperty
   a_smp_hold: assert property (p_smp_hold) else $error("sample not held");
   c_ph_set: cover property (p_ph_set);
   c_smp: cover property (sample_valid && sample_ready);
   c_err: cover property (rvalid && rresp == RESP_SLVERR);
endmodule // ddr_rx_checker

// ### tb/test_ddr_dual_port_data_receiver.sv
// bench for ddr_rx: registers, phase control, output clock, link capture
// assumes ddr_pkg, ddr_rx, ddr_host_model and ddr_rx_checker compiled first
`timescale 1ns/1ps
module test_ddr_dual_port_data_receiver;
   import ddr_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, dl_early, dl_late, sample_valid, sample_ready;
   logic incoming_data_clock, outgoing_data_clock, link_run, rnd_en, seen;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_d;
   logic [3:0]  wstrb, n;
   logic [1:0]  bresp, rresp, rsp;
   logic [4:0]  phase;
   ddr_port_pair_t link_pins;
   ddr_sample_t    sample_data;
   int bad_count = 0, n_tests = 0, cyc = 0;
   ddr_rx dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .incoming_data_clock(incoming_data_clock),
      .link_pins(link_pins), .outgoing_data_clock(outgoing_data_clock),
      .derived_sampling_clock_phase(phase), .dl_early(dl_early), .dl_late(dl_late),
      .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready));
   ddr_host_model u_host (.run(link_run), .incoming_data_clock(incoming_data_clock),
      .link_pins(link_pins));
   // ==========================================================
   // expectations and checks
   function automatic logic [3:0] step_of(logic [3:0] v);
      return (v == 4'h8) ? 4'h9 : v;
   endfunction
   function automatic logic [4:0] ph_of(logic [3:0] v);
      logic [3:0] s;
      s = step_of(v);
      return {s[3], s} + NOMINAL_STEPS;
   endfunction
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ent(input ddr_sample_t got);
      logic [SAMPLE_W-1:0] b;
      b = got.p0_rise;
      n_tests++;
      if (got !== {b, b + 14'h0001, b + 14'h0002, b + 14'h0003}) begin
         bad_count++;
         $display("[ERR] %0t sample entry %h", $time, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========================================================
   // bus master
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd_d = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic clk_seen();
      seen = 1'b0;
      repeat (60) begin
         @(posedge aclk);
         seen = seen | outgoing_data_clock;
      end
   endtask
   // ==========================================================
   // clock, timeout, converter side
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (aresetn && sample_valid && sample_ready) chk_ent(sample_data);
      sample_ready <= rnd_en ? 1'($urandom % 2) : 1'b0;
      if (cyc == 20000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         finish_test();
      end
   end
   // ==========================================================
   // tests
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, dl_early, dl_late} = '0;
      {rnd_en, awaddr, araddr, wdata, wstrb} = '0;
      link_run = 1'b1;
      void'($urandom(32'hB12B));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rnd_en <= 1'b1;
      @(posedge aclk);
      chk_val(32'(phase), 32'h8);
      rd(ADDR_PHASE); chk_val(rd_d, 32'h0);
      rd(ADDR_CLKOUT); chk_val(rd_d, 32'h0);
      clk_seen(); chk_val(32'(seen), 32'h0);
      $display("done reset");
      for (int i = 0; i < 24; i++) begin
         n = (i < 16) ? i[3:0] : 4'($urandom % 16);
         wr(ADDR_PHASE, {28'h0, n}, 4'hF); chk_val(32'(rsp), 32'(RESP_OKAY));
         repeat (3) @(posedge aclk);
         chk_val(32'(phase), 32'(ph_of(n)));
         rd(ADDR_APPLIED); chk_val(rd_d, {28'h0, step_of(n)});
      end
      wr(ADDR_PHASE, 32'h0, 4'hF);
      wr(ADDR_PHASE, 32'h3, 4'h0); chk_val(32'(rsp), 32'(RESP_OKAY));
      rd(ADDR_PHASE); chk_val(rd_d, 32'h0);
      wr(8'h00, 32'h5, 4'hF); chk_val(32'(rsp), 32'(RESP_SLVERR));
      rd(8'h3C); chk_val({rd_d[29:0], rsp}, 32'(RESP_SLVERR));
      $display("done phase");
      rd(ADDR_STATUS); chk_val(rd_d & 32'h84, 32'h84);
      wr(ADDR_PHASE, 32'h80, 4'hF);
      dl_early <= 1'b1;
      repeat (2400) @(posedge aclk);
      chk_val(32'(phase), 32'hF);
      rd(ADDR_STATUS); chk_val(rd_d & 32'hF0, 32'hD0);
      dl_early <= 1'b0;
      dl_late <= 1'b1;
      repeat (4100) @(posedge aclk);
      chk_val(32'(phase), 32'h1);
      rd(ADDR_STATUS); chk_val(rd_d & 32'hF0, 32'hE0);
      dl_late <= 1'b0;
      wr(ADDR_PHASE, 32'h0, 4'hF);
      $display("done auto");
      wr(ADDR_CLKOUT, 32'h40, 4'hF);
      repeat (20) @(posedge aclk);
      clk_seen(); chk_val(32'(seen), 32'h1);
      wr(ADDR_CLKOUT, 32'h0, 4'hF);
      repeat (20) @(posedge aclk);
      clk_seen(); chk_val(32'(seen), 32'h0);
      $display("done clock out");
      rd(ADDR_STATUS); chk_val(rd_d & 32'h2, 32'h2);
      link_run <= 1'b0;
      repeat (1500) @(posedge aclk);
      rd(ADDR_STATUS); chk_val(rd_d & 32'h6, 32'h2);
      wr(ADDR_STATUS, 32'h2, 4'hF);
      rd(ADDR_STATUS); chk_val(rd_d & 32'h6, 32'h0);
      $display("done link loss");
      finish_test();
   end
endmodule // test_ddr_dual_port_data_receiver
bind ddr_rx ddr_rx_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
   .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
   .outgoing_data_clock(outgoing_data_clock),
   .derived_sampling_clock_phase(derived_sampling_clock_phase),
   .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready));
